/* File: dv/testbench.sv */
// self-checking testbench for the virtual logic output unit
`timescale 1ns/1ps
module testbench
    import vlou_pkg::*;
();
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [15:0] rdata;
    logic [15:0] dig_in = 16'h0000;
    logic [127:0] ana_bus = 128'h0;
    logic virtual_logic_output;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    vlou_func_e fl [5] = '{VLOU_F_OR, VLOU_F_AND, VLOU_F_XOR, VLOU_F_NOR,
        VLOU_F_NAND};

    vlou_top uut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .dig_in(dig_in),
        .ana_bus(ana_bus), .virtual_logic_output(virtual_logic_output));

    // 25 mhz clock
    always #20 mclk = ~mclk;

    // watchdog, far above the several hundred cycles the run needs
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: output %b expected %b", $time, got, exp);
        end
    endtask

    // bus cycles leave one idle edge first so strobes never re-assert
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(negedge mclk);
        cmp16(rdata, exp);
    endtask

    task automatic din(input logic [15:0] d);
        @(posedge mclk);
        dig_in <= d;
    endtask

    task automatic ana(input int k, input logic [15:0] v);
        @(posedge mclk);
        ana_bus[16*k +: 16] <= v;
    endtask

    // flip-flop path needs two edges, so three is safe
    task automatic outchk(input logic exp);
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        cmp1(virtual_logic_output, exp);
    endtask

    function automatic logic comb(input logic [3:0] f, input logic a,
        input logic b);
        case (f)
            VLOU_F_AND: return a & b;
            VLOU_F_XOR: return a ^ b;
            VLOU_F_NOR: return !(a | b);
            VLOU_F_NAND: return !(a & b);
            default: return a | b;
        endcase
    endfunction

    // 17 bits so the magnitude of the most negative value is exact
    function automatic logic tst(input logic [2:0] k,
        input logic signed [15:0] v, input logic signed [15:0] t);
        logic signed [16:0] m;
        m = v;
        if (k[2] && m < 0) m = -m;
        case (k[1:0])
            2'h0: return m > t;
            2'h1: return m >= t;
            2'h2: return m < t;
            default: return m <= t;
        endcase
    endfunction

    task automatic s_reset();
        wr(4'hc, 16'hffff);
        for (int a = 0; a <= 12; a++) begin
            if (a != 11) rdchk(a[3:0], (a == 10) ? 16'h0001 : 16'h0000);
        end
        outchk(1'b0);
    endtask

    task automatic s_off();
        din(16'hffff);
        wr(OFS_POLARITY, 16'h0000);
        outchk(1'b0);
        wr(OFS_OUTPUT_MODE, 16'h0009);
        outchk(1'b0);
        wr(OFS_POLARITY, 16'h0001);
    endtask

    task automatic s_digital();
        wr(OFS_OUTPUT_MODE, 16'h0001);
        wr(OFS_INPUT_A_SEL, 16'h0003);
        din(16'h0008);
        outchk(1'b1);
        wr(OFS_POLARITY, 16'h0000);
        outchk(1'b0);
        din(16'h0000);
        outchk(1'b1);
        wr(OFS_POLARITY, 16'h0001);
        wr(OFS_INPUT_B_SEL, 16'h0005);
        rdchk(OFS_INPUT_B_SEL, 16'h0000);
        wr(OFS_OUTPUT_MODE, 16'h0003);
        wr(OFS_INPUT_B_SEL, 16'h0006);
        rdchk(OFS_INPUT_B_SEL, 16'h0000);
        wr(OFS_OUTPUT_MODE, 16'h0004);
        wr(OFS_INPUT_B_SEL, 16'h0005);
        rdchk(OFS_INPUT_B_SEL, 16'h0005);
    endtask

    task automatic s_tests();
        logic [15:0] vals [5] = '{16'hfffa, 16'hfffb, 16'h0000, 16'h0005,
            16'h0006};
        wr(OFS_OUTPUT_MODE, 16'h0003);
        wr(OFS_INPUT_A_SEL, 16'h0012);
        wr(OFS_THRESHOLD_A, 16'h0005);
        for (int k = 0; k < 8; k++) begin
            wr(OFS_TEST_A_KIND, 16'(k));
            for (int i = 0; i < 5; i++) begin
                ana(2, vals[i]);
                outchk(tst(k[2:0], vals[i], 16'h0005));
            end
        end
        // b path: a is 6 > 5, b compares variable 1 below -2
        wr(OFS_OUTPUT_MODE, 16'h0004);
        wr(OFS_TEST_A_KIND, 16'h0000);
        wr(OFS_INPUT_B_SEL, 16'h0011);
        wr(OFS_TEST_B_KIND, 16'h0002);
        wr(OFS_THRESHOLD_B, 16'hfffe);
        wr(OFS_FIRST_FUNC, 16'h0005);
        ana(1, 16'hfff0);
        outchk(1'b1);
        ana(1, 16'h0000);
        outchk(1'b0);
        wr(OFS_OUTPUT_MODE, 16'h0005);
        wr(OFS_INPUT_B_SEL, 16'h0001);
        din(16'h0002);
        outchk(1'b1);
    endtask

    task automatic s_funcs();
        wr(OFS_INPUT_A_SEL, 16'h0000);
        for (int f = 0; f < 5; f++) begin
            wr(OFS_FIRST_FUNC, {12'h000, fl[f]});
            for (int ab = 0; ab < 4; ab++) begin
                din({14'h0000, ab[1:0]});
                outchk(comb(fl[f], ab[0], ab[1]));
            end
        end
        wr(OFS_FIRST_FUNC, 16'h0005);
        wr(OFS_OUTPUT_MODE, 16'h0002);
        din(16'h0001);
        outchk(1'b1);
    endtask

    task automatic s_ff();
        logic [1:0] seq [9] = '{2'b00, 2'b01, 2'b11, 2'b10, 2'b00, 2'b11,
            2'b00, 2'b10, 2'b01};
        logic [1:0] prev;
        logic q;
        logic ea;
        logic eb;
        logic st;
        logic cl;
        wr(OFS_OUTPUT_MODE, 16'h0005);
        wr(OFS_FIRST_FUNC, 16'h0001);
        din(16'h0000);
        din(16'h0002);
        outchk(1'b0);
        prev = 2'b10;
        q = 1'b0;
        for (int f = 1; f <= 4; f++) begin
            wr(OFS_FIRST_FUNC, 16'(f));
            for (int i = 0; i < 9; i++) begin
                din({14'h0000, seq[i]});
                ea = (f <= 2) ? (!prev[0] && seq[i][0]) : (prev[0] && !seq[i][0]);
                eb = (f <= 2) ? (!prev[1] && seq[i][1]) : (prev[1] && !seq[i][1]);
                st = (f % 2 == 1) ? ea : eb;
                cl = (f % 2 == 1) ? eb : ea;
                q = cl ? 1'b0 : (st ? 1'b1 : q);
                prev = seq[i];
                outchk(q);
            end
        end
    endtask

    task automatic s_stage2();
        wr(OFS_FIRST_FUNC, 16'h0000);
        wr(OFS_INPUT_C_SEL, 16'h0003);
        for (int f = 0; f < 5; f++) begin
            wr(OFS_SECOND_FUNC, {12'h000, fl[f]});
            for (int sc = 0; sc < 4; sc++) begin
                din({13'h0000, sc[1], 1'b0, sc[0]});
                outchk(comb(fl[f], sc[0], sc[1]));
            end
        end
        wr(OFS_SECOND_FUNC, 16'h0000);
        wr(OFS_INPUT_C_SEL, 16'h0000);
        din(16'h0004);
        outchk(1'b0);
        rdchk(OFS_STATUS, 16'h0010);
    endtask

    task automatic s_rst();
        wr(OFS_FIRST_FUNC, 16'h0001);
        din(16'h0002);
        din(16'h0001);
        outchk(1'b1);
        din(16'h0000);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        wr(OFS_FIRST_FUNC, 16'h0001);
        wr(OFS_INPUT_B_SEL, 16'h0001);
        wr(OFS_OUTPUT_MODE, 16'h0005);
        outchk(1'b0);
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        s_reset();
        s_off();
        s_digital();
        s_tests();
        s_funcs();
        s_ff();
        s_stage2();
        s_rst();
        summarize();
    end
endmodule

/* File: dv/vlou_assertions.sv */
// port-level assertion checker for the virtual logic output unit
`timescale 1ns/1ps
module vlou_assertions
    import vlou_pkg::*;
(
    input wire logic mclk,                // clock
    input wire logic rstn,                // sync reset, active low
    input wire logic [3:0] addr,          // register address
    input wire logic [15:0] wdata,        // write data
    input wire logic wr_stb,              // write strobe
    input wire logic rd_stb,              // read strobe
    input wire logic [15:0] rdata,        // read data
    input wire logic [15:0] dig_in,       // digital signals
    input wire logic [127:0] ana_bus,     // analog variables
    input wire logic virtual_logic_output // final output
);
    logic [3:0] mode_r;
    logic [4:0] sel_a_r;
    logic [4:0] sel_b_r;
    logic pol_r;
    logic [4:0] sel_c_r;
    logic dig_a;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // shadow settings rebuilt from the write strobes alone
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mode_r <= MODE_RST;
            sel_a_r <= 5'h00;
            sel_b_r <= 5'h00;
            pol_r <= POL_RST;
            sel_c_r <= SEL_C_OFF;
        end else if (wr_stb) begin
            if (addr == OFS_OUTPUT_MODE) mode_r <= wdata[3:0];
            if (addr == OFS_INPUT_A_SEL) sel_a_r <= wdata[4:0];
            // b select is locked in the single-input modes
            if (addr == OFS_INPUT_B_SEL && mode_r != 4'h1 && mode_r != 4'h3)
                sel_b_r <= wdata[4:0];
            if (addr == OFS_POLARITY) pol_r <= wdata[0];
            if (addr == OFS_INPUT_C_SEL) sel_c_r <= wdata[4:0];
        end
    end

    // digital a as the design would pick it
    assign dig_a = dig_in[sel_a_r[3:0]];

    a_off_quiet: assert property (
        (mode_r == 4'h0 || mode_r > 4'h8) |=> !virtual_logic_output)
        else $error("output active while disabled");
    a_digital_path: assert property (
        (mode_r == 4'h1 || mode_r == 4'h2) && !sel_a_r[4] &&
        sel_c_r == SEL_C_OFF |=>
        virtual_logic_output == ($past(dig_a) ~^ $past(pol_r)))
        else $error("digital output or polarity wrong");
    a_rdata_idle: assert property (!rd_stb |=> rdata == 16'h0)
        else $error("read data outside its cycle");
    a_status_out: assert property (rd_stb && addr == OFS_STATUS |=>
        rdata[0] == $past(virtual_logic_output) && rdata[15:5] == 11'h0)
        else $error("status output bit wrong");
    a_unmapped_zero: assert property (rd_stb && addr > OFS_STATUS |=>
        rdata == 16'h0)
        else $error("unmapped read not zero");
    a_mode_back: assert property (rd_stb && addr == OFS_OUTPUT_MODE |=>
        rdata == {12'h000, $past(mode_r)})
        else $error("mode readback wrong");
    a_sel_b_lock: assert property (
        rd_stb && addr == OFS_INPUT_B_SEL |=>
        rdata == {11'h000, $past(sel_b_r)})
        else $error("b select readback wrong");
    a_pol_back: assert property (
        rd_stb && addr == OFS_POLARITY |=> rdata == {15'h0000, $past(pol_r)})
        else $error("polarity readback wrong");
endmodule

bind vlou_top vlou_assertions u_chk (.mclk(mclk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .dig_in(dig_in), .ana_bus(ana_bus),
    .virtual_logic_output(virtual_logic_output));

/* File: hw/vlou_logic.sv */
// two-input boolean combining function
`timescale 1ns/1ps
module vlou_logic
    import vlou_pkg::*;
(
    input wire logic [3:0] func, // function code
    input wire logic a,          // first operand
    input wire logic b,          // second operand
    output logic y               // combined value
);
    // flip-flop codes have no gate form here; they fall back to or
    always_comb begin
        case (func)
            VLOU_F_AND: y = a & b;
            VLOU_F_XOR: y = a ^ b;
            VLOU_F_NOR: y = ~a & ~b;
            VLOU_F_NAND: y = ~a | ~b;
            default: y = a | b;
        endcase
    end
endmodule

/* File: hw/vlou_pkg.sv */
// constants and types shared by the virtual logic output unit
package vlou_pkg;
    // data path widths
    localparam int unsigned VLOU_DW = 16;
    localparam int unsigned VLOU_AW = 4;
    localparam int unsigned VLOU_NDIG = 16;
    localparam int unsigned VLOU_NANA = 8;
    localparam int unsigned VLOU_ANA_BUS_W = VLOU_NANA * VLOU_DW;

    // register offsets on the plain software port
    localparam logic [3:0] OFS_OUTPUT_MODE = 4'h0;
    localparam logic [3:0] OFS_INPUT_A_SEL = 4'h1;
    localparam logic [3:0] OFS_INPUT_B_SEL = 4'h2;
    localparam logic [3:0] OFS_TEST_A_KIND = 4'h3;
    localparam logic [3:0] OFS_TEST_B_KIND = 4'h4;
    localparam logic [3:0] OFS_THRESHOLD_A = 4'h5;
    localparam logic [3:0] OFS_THRESHOLD_B = 4'h6;
    localparam logic [3:0] OFS_FIRST_FUNC = 4'h7;
    localparam logic [3:0] OFS_INPUT_C_SEL = 4'h8;
    localparam logic [3:0] OFS_SECOND_FUNC = 4'h9;
    localparam logic [3:0] OFS_POLARITY = 4'ha;
    localparam logic [3:0] OFS_STATUS = 4'hb;

    // input selection field layout
    localparam int unsigned SEL_W = 5;
    localparam int unsigned SEL_ANA_BIT = 4;
    localparam logic [4:0] SEL_C_OFF = 5'h00;
    localparam logic [4:0] SEL_C_MAX = 5'h10;

    // status register bit positions
    localparam int unsigned ST_OUT_BIT = 0;
    localparam int unsigned ST_RES_A_BIT = 1;
    localparam int unsigned ST_RES_B_BIT = 2;
    localparam int unsigned ST_STAGE1_BIT = 3;
    localparam int unsigned ST_FF_BIT = 4;

    // reset values
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic POL_RST = 1'b1;

    // operating modes
    typedef enum logic [3:0] {
        VLOU_MODE_OFF = 4'h0,
        VLOU_MODE_DIG = 4'h1,
        VLOU_MODE_DDIG = 4'h2,
        VLOU_MODE_ANA = 4'h3,
        VLOU_MODE_DANA = 4'h4,
        VLOU_MODE_DFULL = 4'h5,
        VLOU_MODE_BRK = 4'h6,
        VLOU_MODE_ABRK = 4'h7,
        VLOU_MODE_ALIFT = 4'h8
    } vlou_mode_e;

    // comparison tests
    typedef enum logic [2:0] {
        VLOU_T_GT = 3'h0,
        VLOU_T_GE = 3'h1,
        VLOU_T_LT = 3'h2,
        VLOU_T_LE = 3'h3,
        VLOU_T_AGT = 3'h4,
        VLOU_T_AGE = 3'h5,
        VLOU_T_ALT = 3'h6,
        VLOU_T_ALE = 3'h7
    } vlou_test_e;

    // combining functions
    typedef enum logic [3:0] {
        VLOU_F_OR = 4'h0,
        VLOU_F_SR_RISE = 4'h1,
        VLOU_F_RS_RISE = 4'h2,
        VLOU_F_SR_FALL = 4'h3,
        VLOU_F_RS_FALL = 4'h4,
        VLOU_F_AND = 4'h5,
        VLOU_F_XOR = 4'h6,
        VLOU_F_NOR = 4'h7,
        VLOU_F_NAND = 4'h8
    } vlou_func_e;
endpackage

/* File: hw/vlou_test.sv */
// threshold test of one analog variable
`timescale 1ns/1ps
module vlou_test
    import vlou_pkg::*;
(
    input wire logic [2:0] kind,         // which of eight tests
    input wire logic signed [15:0] value, // selected variable
    input wire logic signed [15:0] thresh, // comparison value
    output logic result                  // test outcome
);
    logic signed [16:0] v_ext;
    logic signed [16:0] t_ext;
    logic signed [16:0] mag;

    // 17 bits so the magnitude of the most negative value stays exact
    always_comb begin
        v_ext = {value[15], value};
        t_ext = {thresh[15], thresh};
        mag = value[15] ? -v_ext : v_ext;
        case (kind)
            VLOU_T_GT: result = v_ext > t_ext;
            VLOU_T_GE: result = v_ext >= t_ext;
            VLOU_T_LT: result = v_ext < t_ext;
            VLOU_T_LE: result = v_ext <= t_ext;
            VLOU_T_AGT: result = mag > t_ext;
            VLOU_T_AGE: result = mag >= t_ext;
            VLOU_T_ALT: result = mag < t_ext;
            default: result = mag <= t_ext;
        endcase
    end
endmodule

/* File: hw/vlou_top.sv */
// virtual logic output unit: tests, combining stages, polarity, registers
//
// Operation
// - digital B skips test and threshold B
// - input B unused in modes 1 and 3
// - signed tests gt, ge, lt, le
// - absolute tests compare magnitude with threshold
// - test A active when mode above 2
// - test B active for modes 4 to 8
// - threshold A feeds test A
// - threshold B feeds test B
// - or true unless both false
// - and true only when both true
// - xor true when exactly one true
// - nor true only when both false
// - nand false only when both true
// - flip-flop modes hold previous value
// - flip-flop modes act on edges only
// - rise A sets, rise B clears
// - rise A clears, rise B sets
// - fall A sets, fall B clears
// - fall A clears, fall B sets
// - combining function active for modes 3 to 8
// - C disabled passes stage one result directly
// - second stage combines with C, same functions; flip-flop codes act as or there
// - polarity 0 inverts, 1 passes
// - disabled mode holds output inactive
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module vlou_top
    import vlou_pkg::*;
(
    input wire logic mclk,              // 25 mhz clock
    input wire logic rstn,              // synchronous reset, active low
    input wire logic [3:0] addr,        // register address
    input wire logic [15:0] wdata,      // register write data
    input wire logic wr_stb,            // write strobe
    input wire logic rd_stb,            // read strobe
    output logic [15:0] rdata,          // read data, cycle after strobe
    input wire logic [15:0] dig_in,     // selectable digital signals
    input wire logic [127:0] ana_bus,   // eight signed 16-bit variables
    output logic virtual_logic_output   // final virtual output
);
    // software settings
    logic [3:0] output_mode_select_r;
    logic [4:0] input_a_select_r;
    logic [4:0] input_b_select_r;
    logic [2:0] test_a_kind_r;
    logic [2:0] test_b_kind_r;
    logic [15:0] threshold_a_r;
    logic [15:0] threshold_b_r;
    logic [3:0] first_stage_function_r;
    logic [4:0] input_c_select_r;
    logic [3:0] second_stage_function_r;
    logic output_polarity_r;

    // processing state
    logic res_a_q_r;
    logic res_b_q_r;
    logic ff_r;
    logic ff_nxt;
    logic out_r;
    logic out_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    // combinational path
    logic mode_test_a_on;
    logic mode_test_b_on;
    logic mode_comb_on;
    logic mode_single;
    logic mode_live;
    logic a_is_ana;
    logic b_is_ana;
    logic [15:0] a_val;
    logic [15:0] b_val;
    logic a_dig;
    logic b_dig;
    logic a_tst;
    logic b_tst;
    logic res_a;
    logic res_b;
    logic rise_a;
    logic rise_b;
    logic fall_a;
    logic fall_b;
    logic ff_set;
    logic ff_clr;
    logic func_is_ff;
    logic lg1_y;
    logic lg2_y;
    logic stage1;
    logic c_on;
    logic [3:0] c_idx;
    logic c_val;
    logic stage2;
    logic b_sel_open;

    // mode decode
    assign mode_live = (output_mode_select_r != VLOU_MODE_OFF) &&
                       (output_mode_select_r <= VLOU_MODE_ALIFT);
    assign mode_test_a_on = output_mode_select_r > VLOU_MODE_DDIG;
    assign mode_test_b_on = (output_mode_select_r > VLOU_MODE_DDIG) &&
                            (output_mode_select_r <= VLOU_MODE_ALIFT);
    assign mode_comb_on = (output_mode_select_r > VLOU_MODE_DDIG) &&
                          (output_mode_select_r <= VLOU_MODE_ALIFT);
    assign mode_single = (output_mode_select_r == VLOU_MODE_DIG) ||
                         (output_mode_select_r == VLOU_MODE_ANA);
    assign b_sel_open = !mode_single;

    // mode register; factory state is disabled
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            output_mode_select_r <= MODE_RST;
        end else if (wr_stb && addr == OFS_OUTPUT_MODE) begin
            output_mode_select_r <= wdata[3:0];
        end
    end

    // input selections; B is locked while a single mode is active
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            input_a_select_r <= 5'h00;
            input_b_select_r <= 5'h00;
            input_c_select_r <= SEL_C_OFF;
        end else if (wr_stb) begin
            if (addr == OFS_INPUT_A_SEL) begin
                input_a_select_r <= wdata[4:0];
            end else if (addr == OFS_INPUT_B_SEL && b_sel_open) begin
                input_b_select_r <= wdata[4:0];
            end else if (addr == OFS_INPUT_C_SEL) begin
                input_c_select_r <= wdata[4:0];
            end
        end
    end

    // test kinds and thresholds
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            test_a_kind_r <= VLOU_T_GT;
            test_b_kind_r <= VLOU_T_GT;
            threshold_a_r <= 16'h0000;
            threshold_b_r <= 16'h0000;
        end else if (wr_stb) begin
            if (addr == OFS_TEST_A_KIND) begin
                test_a_kind_r <= wdata[2:0];
            end else if (addr == OFS_TEST_B_KIND) begin
                test_b_kind_r <= wdata[2:0];
            end else if (addr == OFS_THRESHOLD_A) begin
                threshold_a_r <= wdata;
            end else if (addr == OFS_THRESHOLD_B) begin
                threshold_b_r <= wdata;
            end
        end
    end

    // combining functions and polarity
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            first_stage_function_r <= VLOU_F_OR;
            second_stage_function_r <= VLOU_F_OR;
            output_polarity_r <= POL_RST;
        end else if (wr_stb) begin
            if (addr == OFS_FIRST_FUNC) begin
                first_stage_function_r <= wdata[3:0];
            end else if (addr == OFS_SECOND_FUNC) begin
                second_stage_function_r <= wdata[3:0];
            end else if (addr == OFS_POLARITY) begin
                output_polarity_r <= wdata[0];
            end
        end
    end

    // operand selection; analog variables sit in 16-bit slices
    assign a_is_ana = input_a_select_r[SEL_ANA_BIT];
    assign b_is_ana = input_b_select_r[SEL_ANA_BIT];
    assign a_val = ana_bus[{input_a_select_r[2:0], 4'h0} +: 16];
    assign b_val = ana_bus[{input_b_select_r[2:0], 4'h0} +: 16];
    assign a_dig = dig_in[input_a_select_r[3:0]];
    assign b_dig = dig_in[input_b_select_r[3:0]];

    vlou_test u_test_a (
        .kind(test_a_kind_r),
        .value(a_val),
        .thresh(threshold_a_r),
        .result(a_tst)
    );

    vlou_test u_test_b (
        .kind(test_b_kind_r),
        .value(b_val),
        .thresh(threshold_b_r),
        .result(b_tst)
    );

    // test results; a digital pick bypasses its test and threshold
    always_comb begin
        if (a_is_ana) begin
            res_a = mode_test_a_on & a_tst;
        end else begin
            res_a = a_dig;
        end
        if (mode_single) begin
            res_b = 1'b0;
        end else if (b_is_ana) begin
            res_b = mode_test_b_on & b_tst;
        end else begin
            res_b = b_dig;
        end
    end

    // edge history; a selection change can look like an edge
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            res_a_q_r <= 1'b0;
            res_b_q_r <= 1'b0;
        end else begin
            res_a_q_r <= res_a;
            res_b_q_r <= res_b;
        end
    end

    assign rise_a = res_a & ~res_a_q_r;
    assign rise_b = res_b & ~res_b_q_r;
    assign fall_a = ~res_a & res_a_q_r;
    assign fall_b = ~res_b & res_b_q_r;

    // set and clear events per flip-flop mode
    always_comb begin
        ff_set = 1'b0;
        ff_clr = 1'b0;
        func_is_ff = 1'b1;
        case (first_stage_function_r)
            VLOU_F_SR_RISE: begin
                ff_set = rise_a;
                ff_clr = rise_b;
            end
            VLOU_F_RS_RISE: begin
                ff_set = rise_b;
                ff_clr = rise_a;
            end
            VLOU_F_SR_FALL: begin
                ff_set = fall_a;
                ff_clr = fall_b;
            end
            VLOU_F_RS_FALL: begin
                ff_set = fall_b;
                ff_clr = fall_a;
            end
            default: begin
                func_is_ff = 1'b0;
            end
        endcase
    end

    // clear is checked first so it wins a tie
    always_comb begin
        if (!mode_comb_on) begin
            ff_nxt = ff_r;
        end else if (ff_clr) begin
            ff_nxt = 1'b0;
        end else if (ff_set) begin
            ff_nxt = 1'b1;
        end else begin
            ff_nxt = ff_r;
        end
    end

    // set-reset state
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ff_r <= 1'b0;
        end else begin
            ff_r <= ff_nxt;
        end
    end

    vlou_logic u_stage1 (
        .func(first_stage_function_r),
        .a(res_a),
        .b(res_b),
        .y(lg1_y)
    );

    // stage one; outside modes 3..8 test A passes alone
    always_comb begin
        if (!mode_comb_on) begin
            stage1 = res_a;
        end else if (func_is_ff) begin
            stage1 = ff_r;
        end else begin
            stage1 = lg1_y;
        end
    end

    // third input: 0 is off, 1..16 pick a digital signal
    assign c_on = (input_c_select_r != SEL_C_OFF) &&
                  (input_c_select_r <= SEL_C_MAX);
    assign c_idx = input_c_select_r[3:0] - 4'h1;
    assign c_val = dig_in[c_idx];

    vlou_logic u_stage2 (
        .func(second_stage_function_r),
        .a(stage1),
        .b(c_val),
        .y(lg2_y)
    );

    assign stage2 = c_on ? lg2_y : stage1;

    // polarity last, then disabled mode forces inactive
    always_comb begin
        if (!mode_live) begin
            out_nxt = 1'b0;
        end else if (output_polarity_r) begin
            out_nxt = stage2;
        end else begin
            out_nxt = ~stage2;
        end
    end

    // registered output costs one cycle but keeps it glitch free
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            out_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
        end
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (addr == OFS_OUTPUT_MODE) begin
            rdata_nxt[3:0] = output_mode_select_r;
        end else if (addr == OFS_INPUT_A_SEL) begin
            rdata_nxt[4:0] = input_a_select_r;
        end else if (addr == OFS_INPUT_B_SEL) begin
            rdata_nxt[4:0] = input_b_select_r;
        end else if (addr == OFS_TEST_A_KIND) begin
            rdata_nxt[2:0] = test_a_kind_r;
        end else if (addr == OFS_TEST_B_KIND) begin
            rdata_nxt[2:0] = test_b_kind_r;
        end else if (addr == OFS_THRESHOLD_A) begin
            rdata_nxt = threshold_a_r;
        end else if (addr == OFS_THRESHOLD_B) begin
            rdata_nxt = threshold_b_r;
        end else if (addr == OFS_FIRST_FUNC) begin
            rdata_nxt[3:0] = first_stage_function_r;
        end else if (addr == OFS_INPUT_C_SEL) begin
            rdata_nxt[4:0] = input_c_select_r;
        end else if (addr == OFS_SECOND_FUNC) begin
            rdata_nxt[3:0] = second_stage_function_r;
        end else if (addr == OFS_POLARITY) begin
            rdata_nxt[0] = output_polarity_r;
        end else if (addr == OFS_STATUS) begin
            rdata_nxt[ST_OUT_BIT] = out_r;
            rdata_nxt[ST_RES_A_BIT] = res_a;
            rdata_nxt[ST_RES_B_BIT] = res_b;
            rdata_nxt[ST_STAGE1_BIT] = stage1;
            rdata_nxt[ST_FF_BIT] = ff_r;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata_r <= 16'h0000;
        end else if (rd_stb) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign rdata = rdata_r;
    assign virtual_logic_output = out_r;
endmodule
